// ==== hdl/scc_slave.sv ====
// Purpose: serial byte read/write slave holding clock configuration
// Assumes: scl and sda sampled on clk, far faster than the serial link
// Notes: block transfers and bytes beyond 1 are not served
//
// What this block does
// - byte write: address, command, data, each acknowledged, then stop
// - byte read: command written, repeated start, read address, one byte
// - host leaves read byte unacknowledged, ending the read, then stops
// - command 100xxxxx selects byte access, low five bits give offset
// - slave pulls ack low after address, command and write data
// - byte 0 bits 6,5,4,1 form frequency code, loaded from straps
// - with override bit 3 already set by an earlier write, frequency bits are writable and used
// - override clear by default, frequency bits then read straps
// - byte 0 bit 0 reports latched cpu interface mode strap
// - byte 1 bit 7 spread profile, down or center, resets 0
// - byte 1 bit 6 spread enable, resets 1
// - byte 1 bits 5:4 spread bandwidth, reset to ones
// - byte 1 bit 3 chipset cpu pair enable, resets 1
// - byte 1 bit 2 main cpu pair enable, resets 1
// - byte 1 bit 1 power-down stop state, differential mode only
// - byte 1 bit 0 reports latched current multiplier strap
// - only address byte D2 or its read twin is answered
// - bytes travel most significant bit first
`timescale 1ns/1ns
module scc_slave
  import scc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // serial link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // straps
  input wire logic [3:0] freq_strap,
  input wire logic cpu_iface_mode_strap,
  input wire logic current_multiplier_strap,
  // configuration outputs
  output logic [3:0] freq_code,
  output logic spread_center,
  output logic spread_enable,
  output logic [1:0] spread_bw_sel,
  output logic chipset_cpu_clk_pair_en,
  output logic main_cpu_clk_pair_en,
  output logic pd_stop_hiz
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_CMD = 6'h04,
    ST_WDATA = 6'h08,
    ST_RDATA = 6'h10,
    ST_MACK = 6'h20
  } scc_st_t;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
    scc_st_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic ack;
    logic rd;
    logic byte_op;
    logic [4:0] ofs;
    logic drive_low;
    logic strap_done;
    logic [3:0] strap_fs;
    logic mode_strap;
    logic mult_strap;
    logic ovr;
    logic [3:0] sw_fs;
    logic [7:0] b1;
  } scc_state_t;

  scc_state_t s_r;
  scc_state_t s_nxt;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] rd_now;

  function automatic logic [7:0] rd_byte(input scc_state_t s);
    logic [3:0] fs;
    rd_byte = 8'h00;
    fs = s.ovr ? s.sw_fs : s.strap_fs;
    if (s.byte_op && s.ofs == SCC_OFS_FREQ)
    begin
      rd_byte[SCC_B0_FS2] = fs[2];
      rd_byte[SCC_B0_FS1] = fs[1];
      rd_byte[SCC_B0_FS0] = fs[0];
      rd_byte[SCC_B0_FS3] = fs[3];
      rd_byte[SCC_B0_OVR] = s.ovr;
      rd_byte[SCC_B0_MODE] = s.mode_strap;
    end
    else if (s.byte_op && s.ofs == SCC_OFS_CPU)
    begin
      rd_byte = s.b1 & SCC_B1_WMASK;
      rd_byte[SCC_B1_MULT] = s.mult_strap;
    end
  endfunction

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.scl_s = {s_r.scl_s[0], scl_i};
    s_nxt.sda_s = {s_r.sda_s[0], sda_i};
    s_nxt.scl_d = s_r.scl_s[1];
    s_nxt.sda_d = s_r.sda_s[1];
    scl_rise = s_r.scl_s[1] && !s_r.scl_d;
    scl_fall = !s_r.scl_s[1] && s_r.scl_d;
    start_c = s_r.scl_s[1] && s_r.scl_d && s_r.sda_d && !s_r.sda_s[1];
    stop_c = s_r.scl_s[1] && s_r.scl_d && !s_r.sda_d && s_r.sda_s[1];
    rd_now = rd_byte(s_r);
    if (!s_r.strap_done)
    begin
      s_nxt.strap_done = 1'b1;
      s_nxt.strap_fs = freq_strap;
      s_nxt.sw_fs = freq_strap;
      s_nxt.mode_strap = cpu_iface_mode_strap;
      s_nxt.mult_strap = current_multiplier_strap;
    end
    if (start_c)
    begin
      s_nxt.st = ST_ADDR;
      s_nxt.bitcnt = 4'h0;
      s_nxt.ack = 1'b0;
      s_nxt.drive_low = 1'b0;
    end
    else if (stop_c)
    begin
      s_nxt.st = ST_IDLE;
      s_nxt.drive_low = 1'b0;
    end
    else if (s_r.st != ST_IDLE)
    begin
      if (scl_rise && !s_r.ack)
      begin
        if (s_r.st == ST_MACK)
        begin
          // host nack ends the read, ack sends the byte again
          if (s_r.sda_s[1])
            s_nxt.st = ST_IDLE;
          else
          begin
            s_nxt.st = ST_RDATA;
            s_nxt.shreg = rd_now;
            s_nxt.bitcnt = 4'h0;
          end
        end
        else if (s_r.st != ST_RDATA)
        begin
          s_nxt.shreg = {s_r.shreg[6:0], s_r.sda_s[1]};
          s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        end
      end
      if (scl_fall)
      begin
        if (s_r.ack)
        begin
          s_nxt.ack = 1'b0;
          s_nxt.bitcnt = 4'h0;
          s_nxt.drive_low = 1'b0;
          if (s_r.st == ST_RDATA)
          begin
            s_nxt.drive_low = !rd_now[7];
            s_nxt.shreg = {rd_now[6:0], 1'b0};
            s_nxt.bitcnt = 4'h1;
          end
        end
        else if (s_r.st == ST_RDATA)
        begin
          if (s_r.bitcnt == SCC_BITS_PER_BYTE)
          begin
            s_nxt.st = ST_MACK;
            s_nxt.drive_low = 1'b0;
          end
          else
          begin
            s_nxt.drive_low = !s_r.shreg[7];
            s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
          end
        end
        else if (s_r.bitcnt == SCC_BITS_PER_BYTE && s_r.st != ST_MACK)
        begin
          s_nxt.ack = 1'b1;
          s_nxt.drive_low = 1'b1;
          case (s_r.st)
            ST_ADDR:
            begin
              if (s_r.shreg[7:1] != SCC_DEV_ADDR[7:1])
              begin
                s_nxt.st = ST_IDLE;
                s_nxt.ack = 1'b0;
                s_nxt.drive_low = 1'b0;
              end
              else if (s_r.shreg[0])
              begin
                s_nxt.st = ST_RDATA;
                s_nxt.rd = 1'b1;
              end
              else
              begin
                s_nxt.st = ST_CMD;
                s_nxt.rd = 1'b0;
              end
            end
            ST_CMD:
            begin
              s_nxt.byte_op = s_r.shreg[7:5] == SCC_CMD_BYTE_OP;
              s_nxt.ofs = s_r.shreg[4:0];
              s_nxt.st = ST_WDATA;
            end
            ST_WDATA:
            begin
              // extra bytes are acknowledged and dropped
              if (s_r.byte_op && s_r.ofs == SCC_OFS_FREQ)
              begin
                s_nxt.ovr = s_r.shreg[SCC_B0_OVR];
                if (s_r.ovr)
                  s_nxt.sw_fs = {s_r.shreg[SCC_B0_FS3],
                    s_r.shreg[SCC_B0_FS2], s_r.shreg[SCC_B0_FS1],
                    s_r.shreg[SCC_B0_FS0]};
              end
              else if (s_r.byte_op && s_r.ofs == SCC_OFS_CPU)
                s_nxt.b1 = s_r.shreg & SCC_B1_WMASK;
              s_nxt.byte_op = 1'b0;
            end
            default:
            begin
              s_nxt.st = ST_IDLE;
              s_nxt.ack = 1'b0;
              s_nxt.drive_low = 1'b0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r <= '0;
      s_r.scl_s <= 2'h3;
      s_r.sda_s <= 2'h3;
      s_r.scl_d <= 1'b1;
      s_r.sda_d <= 1'b1;
      s_r.st <= ST_IDLE;
      s_r.b1 <= SCC_B1_RESET;
    end
    else
      s_r <= s_nxt;
  end

  assign sda_o = 1'b0;
  assign sda_oe = s_r.drive_low;
  assign freq_code = s_r.ovr ? s_r.sw_fs : s_r.strap_fs;
  assign spread_center = s_r.b1[SCC_B1_CENTER];
  assign spread_enable = s_r.b1[SCC_B1_SPREAD];
  assign spread_bw_sel = s_r.b1[SCC_B1_BW_HI:SCC_B1_BW_LO];
  assign chipset_cpu_clk_pair_en = s_r.b1[SCC_B1_CS_EN];
  assign main_cpu_clk_pair_en = s_r.b1[SCC_B1_CPU_EN];
  assign pd_stop_hiz = s_r.b1[SCC_B1_PD_HIZ] && !s_r.mode_strap;

  sequence seq_rst_rel;
    $rose(s_r.strap_done);
  endsequence

  // eighth bit of a received byte has just ended
  sequence seq_byte_end;
    scl_fall && !s_r.ack && s_r.bitcnt == SCC_BITS_PER_BYTE;
  endsequence

  AST_RESET_B1: assert property (@(posedge clk)
    disable iff (!arst_n) seq_rst_rel |-> spread_enable
      && chipset_cpu_clk_pair_en && main_cpu_clk_pair_en
      && spread_bw_sel == 2'h3 && !spread_center)
    else $error("byte 1 reset value wrong");
  AST_FS_STRAP: assert property (@(posedge clk)
    disable iff (!arst_n) !s_r.ovr |-> freq_code == s_r.strap_fs)
    else $error("frequency code not from straps");
  AST_ACK_LOW: assert property (@(posedge clk)
    disable iff (!arst_n) s_r.ack |-> sda_oe)
    else $error("ack slot not driven low");
  AST_FOREIGN: assert property (@(posedge clk)
    disable iff (!arst_n) (s_r.st == ST_IDLE && !start_c) |=> !sda_oe)
    else $error("idle slave drives line");
  AST_OVR_GATE: assert property (@(posedge clk)
    disable iff (!arst_n) (s_r.strap_done && !s_r.ovr)
      |=> $stable(s_r.sw_fs))
    else $error("protected frequency bits changed");
  AST_MULT_RO: assert property (@(posedge clk)
    disable iff (!arst_n) s_r.strap_done |=> $stable(s_r.mult_strap)
      && $stable(s_r.mode_strap))
    else $error("strap bits changed");
  AST_B1_BIT0: assert property (@(posedge clk)
    disable iff (!arst_n) !s_r.b1[SCC_B1_MULT])
    else $error("byte 1 bit 0 written");
  AST_STOP_IDLE: assert property (@(posedge clk)
    disable iff (!arst_n) (stop_c && !start_c)
      |=> s_r.st == ST_IDLE && !sda_oe)
    else $error("stop did not end transfer");
  AST_ADDR_ACK: assert property (@(posedge clk)
    disable iff (!arst_n) (s_r.st == ST_ADDR) ##0 seq_byte_end
      ##0 (s_r.shreg[7:1] == SCC_DEV_ADDR[7:1])
      |=> sda_oe && s_r.rd == $past(s_r.shreg[0]))
    else $error("own address not acknowledged");
  AST_ADDR_NACK: assert property (@(posedge clk)
    disable iff (!arst_n) (s_r.st == ST_ADDR) ##0 seq_byte_end
      ##0 (s_r.shreg[7:1] != SCC_DEV_ADDR[7:1])
      |=> !sda_oe && s_r.st == ST_IDLE)
    else $error("foreign address acknowledged");
  AST_CMD_DECODE: assert property (@(posedge clk)
    disable iff (!arst_n) (s_r.st == ST_CMD) ##0 seq_byte_end
      |=> sda_oe && s_r.st == ST_WDATA
      && s_r.ofs == $past(s_r.shreg[4:0])
      && s_r.byte_op == ($past(s_r.shreg[7:5]) == SCC_CMD_BYTE_OP))
    else $error("command code decoded wrongly");
  AST_SW_FS: assert property (@(posedge clk)
    disable iff (!arst_n) (s_r.st == ST_WDATA) ##0 seq_byte_end
      ##0 (s_r.byte_op && s_r.ofs == SCC_OFS_FREQ && s_r.ovr)
      |=> s_r.sw_fs == {$past(s_r.shreg[SCC_B0_FS3]),
      $past(s_r.shreg[SCC_B0_FS2:SCC_B0_FS0])})
    else $error("software frequency code not stored");
  AST_B1_WRITE: assert property (@(posedge clk)
    disable iff (!arst_n) (s_r.st == ST_WDATA) ##0 seq_byte_end
      ##0 (s_r.byte_op && s_r.ofs == SCC_OFS_CPU)
      |=> s_r.b1 == ($past(s_r.shreg) & SCC_B1_WMASK))
    else $error("byte 1 write lost");
  AST_RSVD_ZERO: assert property (@(posedge clk)
    disable iff (!arst_n) (s_r.byte_op && s_r.ofs == SCC_OFS_FREQ)
      |-> !rd_now[7] && !rd_now[2])
    else $error("reserved bits read as one");
  AST_MSB_FIRST: assert property (@(posedge clk)
    disable iff (!arst_n) (scl_fall && s_r.st == ST_RDATA && !s_r.ack
      && s_r.bitcnt != SCC_BITS_PER_BYTE)
      |=> sda_oe == !$past(s_r.shreg[7]))
    else $error("read bit out of order");
  AST_MACK_END: assert property (@(posedge clk)
    disable iff (!arst_n) (s_r.st == ST_MACK && scl_rise && s_r.sda_s[1])
      |=> s_r.st == ST_IDLE && !sda_oe)
    else $error("host nack did not end read");
  AST_ACK_HOLD: assert property (@(posedge clk)
    disable iff (!arst_n) (s_r.ack && !scl_fall && !start_c && !stop_c)
      |=> s_r.ack && sda_oe)
    else $error("ack released early");
endmodule

// ==== common/scc_pkg.sv ====
// Purpose: constants for the serial configuration slave
// Assumes: byte-level serial protocol, msb first
// Notes: only configuration bytes 0 and 1 are implemented
package scc_pkg;
  localparam logic [7:0] SCC_DEV_ADDR = 8'hD2;
  localparam logic [2:0] SCC_CMD_BYTE_OP = 3'h4;
  localparam logic [4:0] SCC_OFS_FREQ = 5'h00;
  localparam logic [4:0] SCC_OFS_CPU = 5'h01;
  // byte 0 fields
  localparam int SCC_B0_FS2 = 6;
  localparam int SCC_B0_FS1 = 5;
  localparam int SCC_B0_FS0 = 4;
  localparam int SCC_B0_OVR = 3;
  localparam int SCC_B0_FS3 = 1;
  localparam int SCC_B0_MODE = 0;
  // byte 1 fields
  localparam int SCC_B1_CENTER = 7;
  localparam int SCC_B1_SPREAD = 6;
  localparam int SCC_B1_BW_HI = 5;
  localparam int SCC_B1_BW_LO = 4;
  localparam int SCC_B1_CS_EN = 3;
  localparam int SCC_B1_CPU_EN = 2;
  localparam int SCC_B1_PD_HIZ = 1;
  localparam int SCC_B1_MULT = 0;
  // byte 1 writable bits and reset value (bit 0 is strap)
  localparam logic [7:0] SCC_B1_WMASK = 8'hFE;
  localparam logic [7:0] SCC_B1_RESET = 8'h7C;
  localparam logic [3:0] SCC_BITS_PER_BYTE = 4'h8;
endpackage

// ==== tb/scc_host.sv ====
// Purpose: behavioural serial host for the configuration slave
// Assumes: sda has a pull-up, scl is driven by the host only
// Notes: bit period 720 ns, scl idles high between frames
`timescale 1ns/1ns
module scc_host
(
  // serial link
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  localparam int HALF = 320;
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // start or repeated start, leaves scl low
  task automatic start();
    #80 sda_pull = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda_pull = 1'b1;
    #HALF scl = 1'b0;
  endtask
  task automatic stop();
    #80 sda_pull = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda_pull = 1'b0;
    #HALF;
  endtask
  task automatic bit_io(input logic b, output logic r);
    #80 sda_pull = !b;
    #HALF scl = 1'b1;
    #HALF r = sda;
    scl = 1'b0;
  endtask
  // eight bits then the ninth, host ack level in mack
  task automatic xbyte(input logic [7:0] tx, input logic mack,
    output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(mack, r);
    ack = !r;
  endtask
endmodule

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the configuration slave
// Assumes: host model drives the serial link
// Notes: table rows first, then repeated read, foreign address and reset cases
`timescale 1ns/1ns
module tb;
  import scc_pkg::*;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [10:0] outs;
  } scc_row_t;
  logic clk = 1'b0;
  logic arst_n;
  logic scl;
  logic sda_pull;
  logic sda_oe;
  logic sda_o;
  logic [3:0] freq_strap;
  logic mode_strap;
  logic mult_strap;
  logic [3:0] freq_code;
  logic center, spread_en, cs_en, main_en, pd_hiz;
  logic [1:0] bw;
  logic [10:0] outs;
  logic [7:0] rx;
  logic [2:0] a;
  logic hack;
  wire sda;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  scc_row_t rows [7] = '{
    '{8'h80, 8'hFF, 8'h2A, 11'h53E},
    '{8'h80, 8'h5C, 8'h58, 11'h2BE},
    '{8'h81, 8'h00, 8'h01, 11'h280},
    '{8'h81, 8'hFF, 8'hFF, 11'h2FF},
    '{8'h82, 8'h55, 8'h00, 11'h2FF},
    '{8'h01, 8'h55, 8'h00, 11'h2FF},
    '{8'h80, 8'h00, 8'h22, 11'h57F}};
  always #20 clk = !clk;
  assign sda = !(sda_pull || (sda_oe && !sda_o));
  assign outs = {freq_code, center, spread_en, bw, cs_en, main_en, pd_hiz};
  scc_slave scc_slave_i (.clk(clk), .arst_n(arst_n), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .freq_strap(freq_strap),
    .cpu_iface_mode_strap(mode_strap),
    .current_multiplier_strap(mult_strap), .freq_code(freq_code),
    .spread_center(center), .spread_enable(spread_en),
    .spread_bw_sel(bw), .chipset_cpu_clk_pair_en(cs_en),
    .main_cpu_clk_pair_en(main_en), .pd_stop_hiz(pd_hiz));
  scc_host scc_host_i (.scl(scl), .sda_pull(sda_pull), .sda(sda));
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    logic [7:0] r;
    logic [2:0] k;
    scc_host_i.start();
    scc_host_i.xbyte(SCC_DEV_ADDR, 1'b1, r, k[2]);
    scc_host_i.xbyte(cmd, 1'b1, r, k[1]);
    scc_host_i.xbyte(d, 1'b1, r, k[0]);
    scc_host_i.stop();
    check(k === 3'h7, "write ack missing");
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] r;
    logic [3:0] k;
    scc_host_i.start();
    scc_host_i.xbyte(SCC_DEV_ADDR, 1'b1, r, k[3]);
    scc_host_i.xbyte(cmd, 1'b1, r, k[2]);
    scc_host_i.start();
    scc_host_i.xbyte(SCC_DEV_ADDR | 8'h01, 1'b1, r, k[1]);
    scc_host_i.xbyte(8'hFF, 1'b1, r, k[0]);
    scc_host_i.stop();
    check(k === 4'hE, "read ack");
    check(r === exp, "read data");
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      wrap_up();
    end
  end
  initial
  begin
    arst_n = 1'b0;
    freq_strap = 4'hA;
    mode_strap = 1'b0;
    mult_strap = 1'b1;
    repeat (12) @(posedge clk);
    #5 arst_n = 1'b1;
    repeat (6) @(posedge clk);
    #5;
    for (int i = 0; i < 7; i++)
    begin
      wr(rows[i].cmd, rows[i].wd);
      rd(rows[i].cmd, rows[i].rd);
      check(outs === rows[i].outs, "outputs");
    end
    // host ack asks for the same byte again, nack then ends the read
    scc_host_i.start();
    scc_host_i.xbyte(SCC_DEV_ADDR, 1'b1, rx, a[2]);
    scc_host_i.xbyte(8'h80, 1'b1, rx, a[1]);
    scc_host_i.start();
    scc_host_i.xbyte(SCC_DEV_ADDR | 8'h01, 1'b1, rx, a[0]);
    scc_host_i.xbyte(8'hFF, 1'b0, rx, hack);
    check(rx === 8'h22 && a === 3'h7, "first read byte");
    scc_host_i.xbyte(8'hFF, 1'b1, rx, hack);
    scc_host_i.stop();
    check(rx === 8'h22 && hack === 1'b0, "resent byte");
    // foreign address, rest of frame must be ignored
    scc_host_i.start();
    scc_host_i.xbyte(8'hD4, 1'b1, rx, a[2]);
    scc_host_i.xbyte(8'h81, 1'b1, rx, a[1]);
    scc_host_i.xbyte(8'h00, 1'b1, rx, a[0]);
    scc_host_i.stop();
    check(a === 3'h0, "foreign acked");
    check(outs === 11'h57F, "foreign write");
    // second reset with other straps
    arst_n = 1'b0;
    freq_strap = 4'h5;
    mode_strap = 1'b1;
    mult_strap = 1'b0;
    repeat (12) @(posedge clk);
    #5 check(outs === 11'h03E, "reset outputs");
    arst_n = 1'b1;
    repeat (6) @(posedge clk);
    #5 check(outs === 11'h2BE, "strap code");
    rd(8'h80, 8'h51);
    rd(8'h81, 8'h7C);
    wr(8'h81, 8'hFF);
    rd(8'h81, 8'hFE);
    check(outs === 11'h2FE, "stop state ignored");
    wrap_up();
  end
endmodule
